/* File: verilog/sar_params.svh */
// sar_params.svh: offsets, field positions, reset values and cycle counts
// assumes: included by the sequencer; register indices are word indices
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH

// register indices, byte address is index times four
`define SAR_IDX_MODE 8'h16
`define SAR_IDX_RES_LO 8'h17
`define SAR_IDX_RES_HI 8'h18
`define SAR_IDX_START 8'h20
`define SAR_IDX_CUROFF 8'h21
`define SAR_IDX_STATUS 8'h24
`define SAR_IDX_CLEAR 8'h25
`define SAR_IDX_ENABLE 8'h26

// field positions
`define SAR_BIT_PERIOD 0
`define SAR_BIT_FLAG 2
`define SAR_BIT_DONE 0

// reset values
`define SAR_MODE_RESET 4'h0

// conversion lengths in instruction cycles
`define SAR_SHORT_CYCLES 7'h22
`define SAR_LONG_CYCLES 7'h43
`define SAR_BITS 7'h08

`endif

/* File: verilog/sar_pkg.sv */
// sar_pkg: types shared by the converter sequencer files
// assumes: nothing beyond the params header
package sar_pkg;
  // one-hot sequencer states
  typedef enum logic [2:0] {
    SAR_IDLE = 3'b001,
    SAR_SAMPLE = 3'b010,
    SAR_APPROX = 3'b100
  } sar_state_e;

  // conversion mode register fields
  typedef struct packed {
    logic [2:0] channel;
    logic long_period;
  } sar_mode_s;
endpackage : sar_pkg

/* File: verilog/sar_tick_div.sv */
// sar_tick_div: instruction cycle enable from the main clock
// assumes: one clock; halt high freezes the divider like a stopped oscillator
`timescale 1ns/100ps
module sar_tick_div #(
  parameter int DIV = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic halt,
  output logic tick
);
  logic [7:0] cnt;

  // count up, pulse once per instruction cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end else if (halt) begin
      tick <= 1'b0;
    end else if (cnt == 8'(DIV - 1)) begin
      cnt <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
      tick <= 1'b0;
    end
  end

  a_tick_halt: assert property (@(posedge clk) disable iff (rst) // RL14
    halt |=> !tick) else $error("tick while halted");
endmodule : sar_tick_div

/* File: verilog/sar_seq.sv */
// sar_seq: 8-bit successive approximation sequencer with Avalon-MM registers
// assumes: comparator answers within one clock; LOW_POWER marks stop, watch, subactive
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/100ps
`include "sar_params.svh"

// Overview of operation
// RL1: eight inputs digitised by successive approximation into 8-bit results
// RL2: conversion mode register is 4 bits, write-only, period and channel
// RL3: mode bit 0 clear gives 34 instruction cycles, set gives 67
// RL4: mode bits 1 to 3 select the analog channel for next conversion
// RL5: channel bits decode binary, zero selects input zero
// RL6: result read-only, low digit and high digit at two addresses
// RL7: result register is not initialised by reset
// RL8: result held stable after completion until the next conversion starts
// RL9: software ignores result reads during a conversion
// RL10: writing 1 to start flag bit 2 launches a conversion
// RL11: on completion result stored and start flag cleared for polling
// RL12: software never writes start flag while a conversion runs
// RL13: current-off flag cuts ladder current in active and standby
// RL14: converter does not run in stop, watch or subactive modes
// RL15: low-power modes cut ladder current regardless of the flag
// RL16: count instruction cycles from start, finish at the chosen length
module sar_seq
  import sar_pkg::*;
#(
  parameter int INSTR_DIV = 4
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [9:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [3:0] BYTEENABLE,
  input wire logic [31:0] WRITEDATA,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  input wire logic COMPARE,
  input wire logic LOW_POWER,
  output logic [7:0] ANALOG_SELECT,
  output logic [7:0] LADDER_CODE,
  output logic LADDER_ON,
  output logic IRQ
);
  sar_state_e state;
  sar_mode_s conversion_mode;
  logic conversion_start_flag;
  logic ladder_current_off_flag;
  logic [7:0] result;
  logic [7:0] code;
  logic [6:0] cnt;
  logic [6:0] conv_len;
  logic done;
  logic tick;
  logic status;
  logic enable;
  logic take;
  logic wr_take;
  logic [7:0] idx;
  logic [31:0] next_readdata;

  // instruction cycle enable, frozen while the oscillator is stopped
  sar_tick_div #(.DIV(INSTR_DIV)) u_div (
    .clk(CLOCK),
    .rst(RESET),
    .halt(LOW_POWER), // RL14
    .tick(tick)
  );

  // bus decode; request is taken on the edge that sees waitrequest low
  assign idx = ADDRESS[9:2];
  assign take = (READ || WRITE) && !WAITREQUEST;
  assign wr_take = take && WRITE && BYTEENABLE[0] && (ADDRESS[1:0] == 2'b00);
  assign conv_len = conversion_mode.long_period ? `SAR_LONG_CYCLES : `SAR_SHORT_CYCLES; // RL3
  assign done = (state == SAR_APPROX) && tick && (cnt == conv_len - 7'h01); // RL16

  // one wait cycle per access, readdata settles with it
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      WAITREQUEST <= 1'b1;
    end else if ((READ || WRITE) && WAITREQUEST) begin
      WAITREQUEST <= 1'b0;
    end else begin
      WAITREQUEST <= 1'b1;
    end
  end

  // read mux; write-only and unmapped words read as zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (ADDRESS[1:0] == 2'b00) begin
      case (idx)
        `SAR_IDX_RES_LO: next_readdata[3:0] = result[3:0]; // RL6
        `SAR_IDX_RES_HI: next_readdata[3:0] = result[7:4]; // RL6
        `SAR_IDX_START: next_readdata[`SAR_BIT_FLAG] = conversion_start_flag; // RL11
        `SAR_IDX_CUROFF: next_readdata[`SAR_BIT_FLAG] = ladder_current_off_flag;
        `SAR_IDX_STATUS: next_readdata[`SAR_BIT_DONE] = status;
        `SAR_IDX_ENABLE: next_readdata[`SAR_BIT_DONE] = enable;
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      READDATA <= 32'h0000_0000;
    end else if (READ && WAITREQUEST) begin
      READDATA <= next_readdata;
    end
  end

  // mode register, write-only nibble
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      conversion_mode <= `SAR_MODE_RESET; // RL2
    end else if (wr_take && idx == `SAR_IDX_MODE) begin
      conversion_mode <= WRITEDATA[3:0]; // RL2 RL4
    end
  end

  // ladder current-off flag
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      ladder_current_off_flag <= 1'b0;
    end else if (wr_take && idx == `SAR_IDX_CUROFF) begin
      ladder_current_off_flag <= WRITEDATA[`SAR_BIT_FLAG];
    end
  end

  // start flag: software sets it, completion clears it
  // writes during a run are dropped so a stray clear cannot abort mid-way
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      conversion_start_flag <= 1'b0;
    end else if (done) begin
      conversion_start_flag <= 1'b0; // RL11
    end else if (wr_take && idx == `SAR_IDX_START && state == SAR_IDLE) begin
      conversion_start_flag <= WRITEDATA[`SAR_BIT_FLAG]; // RL10 RL12
    end
  end

  // sequencer: sample phase, then one bit decision per instruction cycle
  // decisions need INSTR_DIV of 2 or more, the ladder code lags code by a clock
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      state <= SAR_IDLE;
      cnt <= 7'h00;
      code <= 8'h00;
    end else begin
      case (state)
        SAR_IDLE: begin
          if (conversion_start_flag) begin
            state <= SAR_SAMPLE; // RL10
            cnt <= 7'h00;
            code <= 8'h80;
          end
        end
        SAR_SAMPLE: begin
          if (tick) begin
            cnt <= cnt + 7'h01; // RL16
            if (cnt == conv_len - `SAR_BITS - 7'h01) begin
              state <= SAR_APPROX;
            end
          end
        end
        SAR_APPROX: begin
          if (tick) begin
            cnt <= cnt + 7'h01; // RL16
            code <= next_code(code, COMPARE); // RL1
            if (done) begin
              state <= SAR_IDLE;
            end
          end
        end
        default: state <= SAR_IDLE;
      endcase
    end
  end

  // keep the trial bit if input is above the ladder, then try the next one
  function automatic logic [7:0] next_code(input logic [7:0] c, input logic above);
    logic [7:0] low;
    low = c & (~c + 8'h01);
    next_code = (above ? c : (c & ~low)) | (low >> 1);
  endfunction : next_code

  // result has no reset so contents survive a device reset
  always_ff @(posedge CLOCK) begin
    if (done) begin
      result <= next_code(code, COMPARE); // RL7 RL8 RL11
    end
  end

  // analog mux select and ladder drive
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      ANALOG_SELECT <= 8'h01;
      LADDER_CODE <= 8'h00;
      LADDER_ON <= 1'b0;
    end else begin
      ANALOG_SELECT <= 8'h01 << conversion_mode.channel; // RL4 RL5
      LADDER_CODE <= code;
      LADDER_ON <= !ladder_current_off_flag && !LOW_POWER; // RL13 RL15
    end
  end

  // interrupt: sticky done bit, write-one clear, enable gate; set wins
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      status <= 1'b0;
    end else if (done) begin
      status <= 1'b1;
    end else if (wr_take && idx == `SAR_IDX_CLEAR && WRITEDATA[`SAR_BIT_DONE]) begin
      status <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      enable <= 1'b0;
    end else if (wr_take && idx == `SAR_IDX_ENABLE) begin
      enable <= WRITEDATA[`SAR_BIT_DONE];
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= status && enable;
    end
  end

  // checks
  // helper: instruction cycles counted since the sequencer left idle,
  // kept apart from cnt so the length checks do not echo the sequencer
  logic [6:0] chk_ticks;

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      chk_ticks <= 7'h00;
    end else if (state == SAR_IDLE) begin
      chk_ticks <= 7'h00;
    end else if (tick) begin
      chk_ticks <= chk_ticks + 7'h01;
    end
  end

  a_flag_clears: assert property (@(posedge CLOCK) disable iff (RESET) // RL11
    done |=> !conversion_start_flag && state == SAR_IDLE)
    else $error("start flag not cleared on completion");

  // a write to the flag during a run is dropped, so the flag holds until done
  a_flag_busy: assert property (@(posedge CLOCK) disable iff (RESET) // RL11
    (state != SAR_IDLE && !done) |=> conversion_start_flag)
    else $error("start flag dropped during a conversion");

  a_result_hold: assert property (@(posedge CLOCK) disable iff (RESET) // RL8
    !done |=> $stable(result))
    else $error("result changed outside completion");

  a_conv_len: assert property (@(posedge CLOCK) disable iff (RESET) // RL3 RL16
    done |-> chk_ticks == (conversion_mode.long_period ? 7'h42 : 7'h21))
    else $error("conversion length wrong");

  // the last trial bit is bit 0 only after seven earlier decisions
  a_eight_steps: assert property (@(posedge CLOCK) disable iff (RESET) // RL1
    done |-> code[0])
    else $error("completion before the last trial bit");

  a_start_launch: assert property (@(posedge CLOCK) disable iff (RESET) // RL10
    (state == SAR_IDLE && conversion_start_flag) |=> state == SAR_SAMPLE && code == 8'h80)
    else $error("start did not launch");

  a_ladder_cut: assert property (@(posedge CLOCK) disable iff (RESET) // RL13
    (LOW_POWER || ladder_current_off_flag) |=> !LADDER_ON)
    else $error("ladder current not cut");

  // a tick already launched before low power was seen may still land once
  a_lowpow_frozen: assert property (@(posedge CLOCK) disable iff (RESET) // RL14
    (LOW_POWER && state != SAR_IDLE) ##1 LOW_POWER ##1 LOW_POWER |-> $stable(cnt))
    else $error("converter ran in low power");

  // a low-power pulse that ends at once may let the ladder back on
  a_ladder_auto: assert property (@(posedge CLOCK) disable iff (RESET) // RL15
    $rose(LOW_POWER) |=> !LADDER_ON ##1 ($past(LOW_POWER) ? !LADDER_ON : 1'b1))
    else $error("ladder on in low power");

  // one-hot select, so a stray second line cannot short two inputs together
  a_mux_decode: assert property (@(posedge CLOCK) disable iff (RESET) // RL5
    1'b1 |=> $onehot(ANALOG_SELECT) && ANALOG_SELECT[$past(conversion_mode.channel)])
    else $error("channel decode wrong");

  a_approx_steps: assert property (@(posedge CLOCK) disable iff (RESET) // RL1 RL16
    $rose(state == SAR_APPROX) |-> chk_ticks == (conversion_mode.long_period ? 7'h3B : 7'h1A))
    else $error("approximation did not get eight steps");

  a_status_set: assert property (@(posedge CLOCK) disable iff (RESET)
    done |=> status)
    else $error("done status not set");

  a_irq_level: assert property (@(posedge CLOCK) disable iff (RESET)
    1'b1 |=> IRQ == $past(status && enable))
    else $error("interrupt level wrong");
endmodule : sar_seq

/* File: tb/sar_analog_model.sv */
// sar_analog_model: input mux, ladder and comparator facing the sequencer
// assumes: one-hot select; each level is its code plus half an lsb
`timescale 1ns/100ps
module sar_analog_model #(
  parameter logic [63:0] LEVELS = 64'h7E81_C33C_FF00_A55A
) (
  input wire logic CLOCK,
  input wire logic [7:0] ANALOG_SELECT,
  input wire logic [7:0] LADDER_CODE,
  input wire logic LADDER_ON,
  output logic COMPARE
);
  logic toggle = 1'b0;
  logic [7:0] level;
  logic valid;
  // no ladder current means no real decision, so churn the output
  always @(posedge CLOCK) begin
    toggle <= ~toggle;
  end
  // binary channel code arrives one-hot, anything else selects nothing
  always_comb begin
    level = 8'h00;
    valid = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (ANALOG_SELECT == (8'h01 << i)) begin
        level = LEVELS[8*i +: 8];
        valid = 1'b1;
      end
    end
  end
  // half-lsb offset makes the sar result equal the level exactly
  assign COMPARE = (LADDER_ON && valid) ? (LADDER_CODE <= level) : toggle;
endmodule : sar_analog_model

/* File: tb/tb_sar_adc_sequencer.sv */
// tb_sar_adc_sequencer: register-level tests of the conversion sequencer
// assumes: one clock; analog side is the behavioural model
`timescale 1ns/100ps
module tb_sar_adc_sequencer;
  localparam int DIV = 2;
  localparam logic [63:0] LV = 64'h7E81_C33C_FF00_A55A;
  logic CLOCK = 1'b0;
  logic RESET = 1'b1;
  logic [9:0] ADDRESS = 10'h000;
  logic READ = 1'b0;
  logic WRITE = 1'b0;
  logic [3:0] BYTEENABLE = 4'hF;
  logic [31:0] WRITEDATA = 32'h0;
  logic [31:0] READDATA;
  logic WAITREQUEST;
  logic COMPARE;
  logic LOW_POWER = 1'b0;
  logic [7:0] ANALOG_SELECT;
  logic [7:0] LADDER_CODE;
  logic LADDER_ON;
  logic IRQ;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] q;
  logic [31:0] keep;

  sar_seq #(.INSTR_DIV(DIV)) i_sar_seq (.CLOCK(CLOCK), .RESET(RESET), .ADDRESS(ADDRESS),
    .READ(READ), .WRITE(WRITE), .BYTEENABLE(BYTEENABLE), .WRITEDATA(WRITEDATA),
    .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .COMPARE(COMPARE),
    .LOW_POWER(LOW_POWER), .ANALOG_SELECT(ANALOG_SELECT), .LADDER_CODE(LADDER_CODE),
    .LADDER_ON(LADDER_ON), .IRQ(IRQ));
  sar_analog_model #(.LEVELS(LV)) i_sar_analog_model (.CLOCK(CLOCK),
    .ANALOG_SELECT(ANALOG_SELECT), .LADDER_CODE(LADDER_CODE), .LADDER_ON(LADDER_ON),
    .COMPARE(COMPARE));

  // 10 mhz clock
  initial begin
    forever #50 CLOCK = ~CLOCK;
  end
  // hang guard, well above eight long conversions plus a frozen stretch
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end

  task final_report;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // one avalon access; request held until waitrequest is seen low at an edge
  task acc(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge CLOCK);
    ADDRESS <= a;
    WRITE <= w;
    READ <= !w;
    WRITEDATA <= d;
    // waitrequest and readdata are read at the edge, before it updates them
    @(posedge CLOCK);
    while (WAITREQUEST !== 1'b0) @(posedge CLOCK);
    r = READDATA;
    WRITE <= 1'b0;
    READ <= 1'b0;
  endtask : acc

  // one conversion on channel ch, optionally frozen by low power mid-run
  task conv(input int ch, input logic lp, input logic en);
    int len;
    int t0;
    len = DIV * (ch[0] ? 67 : 34) + (lp ? 104 : 0);
    acc(1, 10'h098, {31'h0, en}, q);
    acc(1, 10'h058, {28'h0, ch[2:0], ch[0]}, q);
    repeat (2) @(negedge CLOCK);
    chk("select", 32'h1 << ch, {24'h0, ANALOG_SELECT});
    acc(1, 10'h080, 32'h4, q);
    t0 = cyc;
    acc(0, 10'h080, 32'h0, q);
    chk("flag set", 32'h1, {31'h0, q[2]});
    if (lp) begin
      LOW_POWER <= 1'b1;
      repeat (100) @(posedge CLOCK);
      chk("ladder in low power", 32'h0, {31'h0, LADDER_ON});
      acc(0, 10'h080, 32'h0, q);
      chk("flag frozen", 32'h1, {31'h0, q[2]});
      LOW_POWER <= 1'b0;
    end
    do acc(0, 10'h080, 32'h0, q); while (q[2] !== 1'b0);
    chk("conv time", 32'h1, {31'h0, (cyc - t0 >= len - 8) && (cyc - t0 <= len + 12)});
    acc(0, 10'h05C, 32'h0, q);
    chk("low digit", {28'h0, LV[8*ch +: 4]}, q);
    acc(0, 10'h060, 32'h0, q);
    chk("high digit", {28'h0, LV[8*ch+4 +: 4]}, q);
    acc(0, 10'h090, 32'h0, q);
    chk("done status", 32'h1, q);
    chk("irq", {31'h0, en}, {31'h0, IRQ});
    acc(1, 10'h094, 32'h1, q);
    repeat (2) @(negedge CLOCK);
    chk("irq cleared", 32'h0, {31'h0, IRQ});
  endtask : conv

  // main sequence
  initial begin
    repeat (2) @(posedge CLOCK);
    RESET <= 1'b0;
    @(negedge CLOCK);
    chk("select at reset", 32'h1, {24'h0, ANALOG_SELECT});
    acc(1, 10'h084, 32'h0, q);
    acc(0, 10'h058, 32'h0, q);
    chk("mode write-only", 32'h0, q);
    acc(0, 10'h3FC, 32'h0, q);
    chk("unmapped", 32'h0, q);
    // a mode write with byte lane 0 off must not move the channel
    BYTEENABLE <= 4'h0;
    acc(1, 10'h058, 32'h0000_000E, q);
    BYTEENABLE <= 4'hF;
    repeat (2) @(negedge CLOCK);
    chk("byte lane 0 off", 32'h1, {24'h0, ANALOG_SELECT});
    for (int ch = 0; ch < 8; ch++) begin
      conv(ch, ch == 5, ch != 6);
    end
    // mode now holds a nonzero value, yet must still read as zero
    acc(0, 10'h058, 32'h0, q);
    chk("mode reads zero", 32'h0, q);
    acc(0, 10'h05C, 32'h0, keep);
    acc(1, 10'h05C, 32'hFFFF_FFFF, q);
    repeat (20) @(posedge CLOCK);
    acc(0, 10'h05C, 32'h0, q);
    chk("result held", keep, q);
    acc(1, 10'h084, 32'h4, q);
    repeat (2) @(negedge CLOCK);
    chk("ladder off", 32'h0, {31'h0, LADDER_ON});
    acc(1, 10'h084, 32'h0, q);
    repeat (2) @(negedge CLOCK);
    chk("ladder on", 32'h1, {31'h0, LADDER_ON});
    @(posedge CLOCK);
    RESET <= 1'b1;
    repeat (2) @(posedge CLOCK);
    RESET <= 1'b0;
    acc(0, 10'h05C, 32'h0, q);
    chk("result kept by reset", keep, q);
    final_report();
  end
endmodule : tb_sar_adc_sequencer
